/* File: common/lcdhp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface lcdhp_if;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       hw_rst_n;
    logic [15:0] host_addr_bus;
    logic [7:0] host_dout;
    logic       host_doe;
    logic [7:0] dev_dout;
    logic       dev_doe;
    logic [7:0] host_data_bus;
    logic       wait_out;
    logic       wait_oe;
    logic       wait_n;

    // Undriven lines float high through pull-ups.
    assign host_data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hff);
    assign wait_n        = wait_oe ? wait_out : 1'b1;

    modport host (
        output cs_n, rd_n, wr_n, hw_rst_n, host_addr_bus, host_dout, host_doe,
        input  host_data_bus, wait_n
    );
    modport dev (
        input  cs_n, rd_n, wr_n, hw_rst_n, host_addr_bus, host_data_bus,
        output dev_dout, dev_doe, wait_out, wait_oe
    );
endinterface
`default_nettype wire

/* File: common/lcdhp_pkg.sv */
// Overview of operation
// RULE1 - Host holds hardware reset low at least 1 ms.
// RULE2 - Controller ignores bus accesses during reset.
// RULE3 - Panel outputs halted while reset is asserted.
// RULE4 - Host waits 3 ms after reset release.
// RULE5 - Host may issue init commands right after wait.
// RULE6 - Panel power off one frame from reset start.
// RULE7 - Wait driven low after strobe, released after rise.
// RULE8 - Wait active no longer than 4 clocks.
// RULE9 - Read data valid before wait rises.
// RULE10 - Write data set up 2 clocks before rise.
// RULE11 - Minimum strobe recovery depends on access pair.
// RULE12 - No-wait variant strobe active five clocks minimum.
// RULE13 - No-wait variant minimum cycle time per pair.
// RULE14 - No-wait read data valid within 4 clocks.
// RULE15 - Controller drives data only during a read.
// RULE16 - Input clock must not exceed 60 MHz.
// RULE17 - Both ends count system clocks for timing.
package lcdhp_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 40;
    localparam int SYS_FREQ_MHZ  = 25;
    localparam int CLKIN_MAX_MHZ = 60; // RULE16

    // Least time in periods plus nanoseconds, rounded up to cycles.
    function automatic int cyc_min(input int ts, input int ns);
        return ts + (ns + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    endfunction

    // Longest time in periods plus nanoseconds, rounded down, never zero.
    function automatic int cyc_max(input int ts, input int ns);
        int c;
        c = ts + ns / SYS_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------
    localparam int RESET_MIN_US = 1000;
    localparam int STAB_MAX_US  = 3000;
    localparam int RESET_CYC    = RESET_MIN_US * 1000 / SYS_PERIOD_NS;
    localparam int STAB_CYC     = (STAB_MAX_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // ------------------------------------------------------------
    // Strobe timing in system clock periods plus nanoseconds
    // ------------------------------------------------------------
    localparam int STRB_ACT_TS  = 5;
    localparam int WR_SETUP_TS  = 2;
    localparam int WR_SETUP_NS  = 5;
    localparam int REC_RD_TS    = 1;
    localparam int REC_WW_TS    = 2;
    localparam int REC_WW_NS    = 2;
    localparam int REC_WR_TS    = 5;
    localparam int REC_WR_NS    = 2;
    localparam int CYC_RD_TS    = 6;
    localparam int CYC_WW_TS    = 7;
    localparam int CYC_WW_NS    = 2;
    localparam int CYC_WR_TS    = 10;
    localparam int CYC_WR_NS    = 2;
    localparam int WAIT_MAX_TS  = 4;
    localparam int WAIT_MAX_NS  = 2;
    localparam int RDV_MAX_TS   = 4;
    localparam int RDV_MAX_NS   = 18;
    localparam int TURN_CYC     = 4;

    localparam int STRB_CYC     = cyc_min(STRB_ACT_TS, 0);
    localparam int WR_SETUP_CYC = cyc_min(WR_SETUP_TS, WR_SETUP_NS);
    localparam int GAP_RD_CYC   = max2(TURN_CYC, max2(cyc_min(REC_RD_TS, 0),
                                      cyc_min(CYC_RD_TS, 0) - STRB_CYC));
    localparam int GAP_WW_CYC   = max2(cyc_min(REC_WW_TS, REC_WW_NS),
                                      cyc_min(CYC_WW_TS, CYC_WW_NS) - STRB_CYC);
    localparam int GAP_WR_CYC   = max2(cyc_min(REC_WR_TS, REC_WR_NS),
                                      cyc_min(CYC_WR_TS, CYC_WR_NS) - STRB_CYC);
    localparam int WAIT_CYC     = cyc_max(WAIT_MAX_TS, WAIT_MAX_NS);
    localparam int RDV_CYC      = cyc_max(RDV_MAX_TS, RDV_MAX_NS);

    // ------------------------------------------------------------
    // Register store and panel scan
    // ------------------------------------------------------------
    localparam int REG_NUM           = 16;
    localparam int PANEL_LINE_CYC    = 64;
    localparam int PANEL_FRAME_LINES = 240;
    localparam int FRAME_CYC         = PANEL_LINE_CYC * PANEL_FRAME_LINES;

    typedef enum logic [4:0] {
        HST_RST  = 5'b0_0001,
        HST_STAB = 5'b0_0010,
        HST_IDLE = 5'b0_0100,
        HST_GAP  = 5'b0_1000,
        HST_STRB = 5'b1_0000
    } lcdhp_host_st_e;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_ACT  = 2'b10
    } lcdhp_dev_st_e;

endpackage

/* File: src/lcdhp_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module lcdhp_dev (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       use_wait,
    output logic            acc_wr,
    output logic [15:0]     acc_addr,
    output logic [7:0]      acc_wdata,
    output logic [3:0]      panel_pixel_data,
    output logic            panel_line_pulse,
    output logic            panel_frame_toggle,
    lcdhp_if.dev            bus
);
    typedef struct packed {
        lcdhp_pkg::lcdhp_dev_st_e st;
        logic                     is_rd;
        logic [2:0]               wait_cnt;
        logic                     wait_out;
        logic                     wait_oe;
        logic [7:0]               dout;
        logic                     doe;
        logic [15:0]              addr;
        logic [7:0]               wdata;
        logic                     wr_p;
        logic [15:0][7:0]         regs;
        logic [7:0]               line_cnt;
        logic [7:0]               line_num;
        logic                     line_p;
        logic                     tog;
        logic [3:0]               pix;
    } lcdhp_dev_s;

    localparam lcdhp_dev_s DEV_RST = '{
        st: lcdhp_pkg::DEV_IDLE, wait_out: 1'b1, default: '0};

    lcdhp_dev_s r;
    lcdhp_dev_s n;
    logic       cs_n_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic       hrst_n_s;
    logic [15:0] addr_s;
    logic [7:0] data_s;
    logic       rd_act;
    logic       wr_act;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    lcdhp_sync #(
        .WIDTH   (28),
        .RST_VAL (28'he00_0000)
    ) lcdhp_sync_i (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({bus.cs_n, bus.rd_n, bus.wr_n, bus.hw_rst_n,
                   bus.host_addr_bus, bus.host_data_bus}),
        .q       ({cs_n_s, rd_n_s, wr_n_s, hrst_n_s, addr_s, data_s})
    );

    assign rd_act = !cs_n_s && !rd_n_s;
    assign wr_act = !cs_n_s && !wr_n_s;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n      = r;
        n.wr_p = 1'b0;
        unique case (r.st)
            lcdhp_pkg::DEV_IDLE: begin
                if (hrst_n_s && (rd_act || wr_act)) begin // RULE2
                    n.st       = lcdhp_pkg::DEV_ACT;
                    n.is_rd    = rd_act;
                    n.addr     = addr_s;
                    n.wait_oe  = use_wait; // RULE7
                    n.wait_out = 1'b0;
                    n.wait_cnt = 3'd1;
                    n.dout     = r.regs[addr_s[3:0]]; // RULE14
                    n.doe      = rd_act; // RULE15
                end
            end
            lcdhp_pkg::DEV_ACT: begin
                if (wr_act) begin
                    n.wdata = data_s;
                    n.addr  = addr_s;
                end
                if (r.wait_cnt < 3'(lcdhp_pkg::WAIT_CYC)) begin // RULE8 RULE17
                    n.wait_cnt = r.wait_cnt + 3'd1;
                end else begin
                    n.wait_out = 1'b1; // RULE9
                end
                if (!hrst_n_s) begin
                    n.st       = lcdhp_pkg::DEV_IDLE; // RULE2
                    n.doe      = 1'b0;
                    n.wait_oe  = 1'b0;
                    n.wait_out = 1'b1;
                end else if (!rd_act && !wr_act) begin
                    n.st       = lcdhp_pkg::DEV_IDLE;
                    n.doe      = 1'b0; // RULE15
                    n.wait_oe  = 1'b0; // RULE7
                    n.wait_out = 1'b1;
                    if (!r.is_rd) begin
                        n.regs[r.addr[3:0]] = r.wdata;
                        n.wr_p              = 1'b1;
                    end
                end
            end
            default: begin
                n = DEV_RST;
            end
        endcase

        // Panel scan stops and outputs go quiet while reset is held.
        n.line_p = 1'b0;
        if (!hrst_n_s) begin // RULE3
            n.line_cnt = 8'h00;
            n.line_num = 8'h00;
            n.tog      = 1'b0;
            n.pix      = 4'h0;
        end else begin
            n.pix = r.regs[r.line_cnt[3:0]][3:0];
            if (r.line_cnt == 8'(lcdhp_pkg::PANEL_LINE_CYC - 1)) begin
                n.line_cnt = 8'h00;
                n.line_p   = 1'b1;
                if (r.line_num == 8'(lcdhp_pkg::PANEL_FRAME_LINES - 1)) begin
                    n.line_num = 8'h00;
                    n.tog      = !r.tog;
                end else begin
                    n.line_num = r.line_num + 8'h01;
                end
            end else begin
                n.line_cnt = r.line_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= DEV_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.dev_dout        = r.dout;
    assign bus.dev_doe         = r.doe;
    assign bus.wait_out        = r.wait_out;
    assign bus.wait_oe         = r.wait_oe;
    assign acc_wr              = r.wr_p;
    assign acc_addr            = r.addr;
    assign acc_wdata           = r.wdata;
    assign panel_pixel_data    = r.pix;
    assign panel_line_pulse    = r.line_p;
    assign panel_frame_toggle  = r.tog;
endmodule // lcdhp_dev
`default_nettype wire

/* File: src/lcdhp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module lcdhp_host #(
    parameter int RESET_CYC = lcdhp_pkg::RESET_CYC,
    parameter int STAB_CYC  = lcdhp_pkg::STAB_CYC,
    parameter int FRAME_CYC = lcdhp_pkg::FRAME_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        use_wait,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             ctrl_ready,
    output logic             panel_pwr_en,
    lcdhp_if.host            bus
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        lcdhp_pkg::lcdhp_host_st_e st;
        logic [23:0]               cnt;
        logic [23:0]               pwr_cnt;
        logic [3:0]                gap;
        logic                      last_wr;
        logic                      pend_rd;
        logic                      saw_wait;
        logic                      op_wr;
        logic [15:0]               op_addr;
        logic [7:0]                op_data;
        logic                      cs_n;
        logic                      rd_n;
        logic                      wr_n;
        logic                      hrst_n;
        logic [7:0]                dout;
        logic                      doe;
        logic                      ready;
        logic                      rsp_v;
        logic [7:0]                rsp_d;
        logic                      cready;
        logic                      pwr_en;
    } lcdhp_host_s;

    localparam lcdhp_host_s HOST_RST = '{
        st:      lcdhp_pkg::HST_RST,
        gap:     4'hf,
        cs_n:    1'b1,
        rd_n:    1'b1,
        wr_n:    1'b1,
        default: '0
    };

    lcdhp_host_s r;
    lcdhp_host_s n;
    logic        wait_s;
    logic [7:0]  data_s;
    logic [3:0]  need;

    // ------------------------------------------------------------
    // Recovery needed between the previous strobe and the next one
    // ------------------------------------------------------------
    function automatic logic [3:0] gap_need(input logic prev_wr, input logic next_wr);
        logic [3:0] g;
        g = 4'(lcdhp_pkg::GAP_RD_CYC);
        if (prev_wr) begin
            g = next_wr ? 4'(lcdhp_pkg::GAP_WW_CYC) : 4'(lcdhp_pkg::GAP_WR_CYC);
        end
        return g;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    lcdhp_sync #(
        .WIDTH   (9),
        .RST_VAL (9'h1ff)
    ) lcdhp_sync_i (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({bus.wait_n, bus.host_data_bus}),
        .q       ({wait_s, data_s})
    );

    assign need = gap_need(r.last_wr, r.op_wr);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n       = r;
        n.rsp_v = 1'b0;

        // Cycles since the last strobe rose, saturating.
        if (r.gap != 4'hf) begin // RULE17
            n.gap = r.gap + 4'h1;
        end

        // Panel supply stays off for one frame from the reset start.
        if (r.pwr_cnt < 24'(FRAME_CYC - 1)) begin // RULE6
            n.pwr_cnt = r.pwr_cnt + 24'h00_0001;
        end else begin
            n.pwr_en = 1'b1;
        end

        // Read data is taken once the synchronised bus has settled.
        if (r.pend_rd && r.gap == 4'h2) begin
            n.rsp_v   = 1'b1;
            n.rsp_d   = data_s;
            n.pend_rd = 1'b0;
        end

        unique case (r.st)
            lcdhp_pkg::HST_RST: begin
                n.hrst_n = 1'b0;
                if (r.cnt >= 24'(RESET_CYC - 1)) begin // RULE1
                    n.cnt    = 24'h00_0000;
                    n.hrst_n = 1'b1;
                    n.st     = lcdhp_pkg::HST_STAB;
                end else begin
                    n.cnt = r.cnt + 24'h00_0001;
                end
            end
            lcdhp_pkg::HST_STAB: begin
                if (r.cnt >= 24'(STAB_CYC - 1)) begin // RULE4
                    n.st     = lcdhp_pkg::HST_IDLE;
                    n.cready = 1'b1; // RULE5
                    n.ready  = 1'b1;
                end else begin
                    n.cnt = r.cnt + 24'h00_0001;
                end
            end
            lcdhp_pkg::HST_IDLE: begin
                if (req_valid) begin
                    n.st      = lcdhp_pkg::HST_GAP;
                    n.ready   = 1'b0;
                    n.op_wr   = req_write;
                    n.op_addr = req_addr;
                    n.op_data = req_wdata;
                    n.cs_n    = 1'b0;
                end else begin
                    n.cs_n = 1'b1;
                end
            end
            lcdhp_pkg::HST_GAP: begin
                if (r.gap >= need) begin // RULE11
                    n.st       = lcdhp_pkg::HST_STRB;
                    n.rd_n     = r.op_wr;
                    n.wr_n     = !r.op_wr;
                    n.dout     = r.op_data;
                    n.doe      = r.op_wr; // RULE10
                    n.cnt      = 24'h00_0001;
                    n.saw_wait = 1'b0;
                end
            end
            lcdhp_pkg::HST_STRB: begin
                n.cnt = r.cnt + 24'h00_0001;
                if (!wait_s) begin
                    n.saw_wait = 1'b1;
                end
                if (use_wait ? (r.saw_wait && wait_s) // RULE7
                             : (r.cnt >= 24'(lcdhp_pkg::STRB_CYC))) begin // RULE12
                    n.st      = lcdhp_pkg::HST_IDLE;
                    n.rd_n    = 1'b1;
                    n.wr_n    = 1'b1;
                    n.doe     = 1'b0;
                    n.gap     = 4'h1; // RULE13
                    n.last_wr = r.op_wr;
                    n.pend_rd = !r.op_wr;
                    n.ready   = 1'b1;
                end
            end
            default: begin
                n = HOST_RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.cs_n          = r.cs_n;
    assign bus.rd_n          = r.rd_n;
    assign bus.wr_n          = r.wr_n;
    assign bus.hw_rst_n      = r.hrst_n;
    assign bus.host_addr_bus = r.op_addr;
    assign bus.host_dout     = r.dout;
    assign bus.host_doe      = r.doe;
    assign req_ready         = r.ready;
    assign rsp_valid         = r.rsp_v;
    assign rsp_rdata         = r.rsp_d;
    assign ctrl_ready        = r.cready;
    assign panel_pwr_en      = r.pwr_en;
endmodule // lcdhp_host
`default_nettype wire

/* File: src/lcdhp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lcdhp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // lcdhp_sync
`default_nettype wire

/* File: tb/lcdhp_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module lcdhp_bench;
    localparam int RST_C = 20;
    localparam int STB_C = 30;
    localparam int FRM_C = 40;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        use_wait = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready, rsp_valid, ctrl_ready, panel_pwr_en, acc_wr;
    logic        panel_line_pulse, panel_frame_toggle;
    logic [7:0]  rsp_rdata, acc_wdata, e_rd;
    logic [15:0] acc_addr;
    logic [3:0]  panel_pixel_data;
    logic [5:0]  panel_out;
    int          line_gap = -1;
    logic [23:0] e_wr;
    logic [7:0]  shadow [16];
    logic [7:0]  rd_q [$];
    logic [23:0] wr_q [$];
    int          num_errors = 0;
    int          n_compared = 0;

    always #20 clk_sys = ~clk_sys;

    assign panel_out = {panel_pixel_data, panel_line_pulse, panel_frame_toggle};

    lcdhp_if bus_if ();
    lcdhp_host #(.RESET_CYC(RST_C), .STAB_CYC(STB_C), .FRAME_CYC(FRM_C)) lcdhp_host_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .use_wait(use_wait), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .ctrl_ready(ctrl_ready), .panel_pwr_en(panel_pwr_en), .bus(bus_if));
    lcdhp_dev lcdhp_dev_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .use_wait(use_wait), .acc_wr(acc_wr),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .panel_pixel_data(panel_pixel_data),
        .panel_line_pulse(panel_line_pulse), .panel_frame_toggle(panel_frame_toggle),
        .bus(bus_if));
    lcdhp_monitor lcdhp_monitor_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
        .hw_rst_n(bus_if.hw_rst_n), .host_doe(bus_if.host_doe), .dev_doe(bus_if.dev_doe),
        .wait_oe(bus_if.wait_oe), .wait_n(bus_if.wait_n));

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        `CHK(what, 1'b1, 1'b0)
        close_out();
    endtask

    // ------------------------------------------------------------
    // Result watchers
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            e_rd = (rd_q.size() != 0) ? rd_q.pop_front() : 8'hxx;
            `CHK("rd_data", e_rd, rsp_rdata)
        end
        if (acc_wr === 1'b1) begin
            e_wr = (wr_q.size() != 0) ? wr_q.pop_front() : 24'hxx_xxxx;
            `CHK("wr_commit", e_wr, {acc_addr, acc_wdata})
        end
        if (rst_n !== 1'b1) begin
            line_gap = -1;
        end else if (panel_line_pulse === 1'b1) begin
            if (line_gap >= 0) `CHK("line_period", lcdhp_pkg::PANEL_LINE_CYC, line_gap)
            line_gap = 1;
        end else if (line_gap >= 0) begin
            line_gap++;
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic do_reset(input logic w);
        int i;
        int n_hw;
        int n_pwr;
        rst_n <= 1'b0;
        use_wait <= w;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        n_hw = 0;
        n_pwr = 0;
        for (i = 0; i < 1000 && ctrl_ready !== 1'b1; i++) begin
            @(posedge clk_sys);
            if (bus_if.hw_rst_n === 1'b0) begin
                n_hw++;
                `CHK("panel_halt", 6'h00, panel_out)
            end
            if (panel_pwr_en === 1'b0) n_pwr++;
        end
        if (i >= 1000) give_up("ready_wait");
        `CHK("rst_len", 1'b1, n_hw >= RST_C)
        `CHK("stab_len", 1'b1, i - n_hw >= STB_C)
        `CHK("pwr_off", 1'b1, n_pwr >= FRM_C)
        `CHK("pwr_on", 1'b1, panel_pwr_en)
        for (i = 0; i < 16; i++) shadow[i] = 8'h00;
        $display("test reset done");
    endtask

    task automatic req(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        if (n >= 200) give_up("req_ready");
        if (w) begin
            shadow[a[3:0]] = d;
            wr_q.push_back({a, d});
        end else begin
            rd_q.push_back(shadow[a[3:0]]);
        end
    endtask

    initial begin
        int m;
        int k;
        int n;
        logic [15:0] a;
        void'($urandom(57));
        for (m = 0; m < 2; m++) begin
            do_reset(m[0]);
            for (k = 0; k < 16; k++) begin
                a = 16'($urandom);
                a[3:0] = k[3:0];
                req(1'b0, a, 8'h00);
            end
            for (k = 0; k < 48; k++) req(1'($urandom), 16'($urandom), 8'($urandom));
            req_valid <= 1'b0;
            for (n = 0; n < 500 && (rd_q.size() != 0 || wr_q.size() != 0); n++) begin
                @(posedge clk_sys);
            end
            if (n >= 500) give_up("drain");
            repeat (10) @(posedge clk_sys);
            $display("test mode %0d done", m);
        end
        close_out();
    end
endmodule // lcdhp_bench
`default_nettype wire

/* File: tb/lcdhp_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module lcdhp_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic hw_rst_n,
    input wire logic host_doe,
    input wire logic dev_doe,
    input wire logic wait_oe,
    input wire logic wait_n
);
    // ------------------------------------------------------------
    // Bus relations between the two ends
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_no_fight: assert property (!(dev_doe && host_doe))
        else $error("both ends drive the data bus");
    a_doe_start: assert property ($rose(dev_doe) |-> !rd_n)
        else $error("device drives data outside a read");
    a_doe_release: assert property ($rose(rd_n) |-> ##[1:5] !dev_doe)
        else $error("device holds the data bus after read end");
    a_strobe_width: assert property ($fell(rd_n && wr_n) |-> (!(rd_n && wr_n))[*5])
        else $error("strobe shorter than five cycles");
    a_write_setup: assert property ($rose(wr_n) |->
        $past(host_doe) && $past(host_doe, 3))
        else $error("write data not set up before strobe end");
    a_read_recov: assert property ($rose(rd_n) |-> (rd_n && wr_n)[*4])
        else $error("recovery after read too short");
    a_write_recov: assert property ($rose(wr_n) |->
        (rd_n && wr_n)[*3] ##1 rd_n[*3])
        else $error("recovery after write too short");
    a_rd_access: assert property ($fell(rd_n) |-> ##[1:4] dev_doe)
        else $error("read data not driven in time");
    a_wait_cause: assert property ($fell(wait_n) |-> !rd_n || !wr_n)
        else $error("wait asserted without a strobe");
    a_wait_bound: assert property ($fell(wait_n) |-> ##[1:4] wait_n)
        else $error("wait held too long");
    a_wait_release: assert property ($rose(rd_n) || $rose(wr_n) |-> ##[1:5] !wait_oe)
        else $error("wait still driven after strobe end");
    a_rd_valid: assert property ($rose(wait_n) |-> dev_doe || rd_n)
        else $error("read data not driven when wait ends");
    a_rst_quiet: assert property (!hw_rst_n[*4] |-> !dev_doe && !wait_oe)
        else $error("device drives the bus during reset");
endmodule // lcdhp_monitor
`default_nettype wire
